//--- rtl/dvt_pkg.sv
// constants for the dma vector and trigger handshake block
// assumes a single mclk domain; all peripherals on-chip and synchronous
package dvt_pkg;
	localparam int NCHAN = 3;
	localparam logic [3:0] VEC_NONE  = 4'h0;
	localparam logic [3:0] VEC_CHAN0 = 4'h2;
	localparam logic [3:0] VEC_CHAN1 = 4'h4;
	localparam logic [3:0] VEC_CHAN2 = 4'h6;
	localparam int VEC_W = 16;
	localparam logic [1:0] SEQ_SINGLE      = 2'h0;
	localparam logic [1:0] SEQ_SEQUENCE    = 2'h1;
	localparam logic [1:0] SEQ_REPEAT      = 2'h2;
	localparam logic [1:0] SEQ_REPEAT_SEQ  = 2'h3;
	localparam int SAR_SLOTS = 16;
	localparam int SD_CHANS  = 3;
endpackage

//--- rtl/dvt_core.sv
// dma completion vector generator and peripheral trigger handshake
// assumes peripherals and cpu run on mclk_i; all inputs are same-domain
// Contract
// - merge three done flags into one source
// - vector shows lowest-numbered enabled pending channel only
// - any vector access clears reported flag
// - remaining enabled flag re-raises request immediately
// - chan0 reported before chan2, chan2 stays
// - vector values 0,2,4,6; 8-14 never
// - vector value even, jump-table offset
// - serial rx flag triggers, cleared on ack
// - rx irq enable blocks rx trigger
// - serial tx flag triggers, cleared on ack
// - tx irq enable blocks tx trigger
// - modes 0,2: conversion slot flag triggers
// - modes 1,3: only last slot triggers
// - sar flag clears on slot access
// - dac flag clears on data access
// - grouped mode: master channel triggers only
// - ungrouped: sigma-delta channel 0 triggers
// - sigma-delta flag clears on result access
// - triggers need no cpu, any power mode
// - done flag set at zero, software clears
// - request needs flag, enable and global enable
module dvt_core #(
	parameter int SAR_SLOTS = dvt_pkg::SAR_SLOTS,
	parameter int SD_CHANS  = dvt_pkg::SD_CHANS
) (
	input  wire logic                       mclk_i,
	input  wire logic                       nrst_i,
	// completion side
	input  wire logic [dvt_pkg::NCHAN-1:0]  size_zero_i,
	input  wire logic [dvt_pkg::NCHAN-1:0]  sw_flag_clr_i,
	input  wire logic [dvt_pkg::NCHAN-1:0]  channel_irq_enable_i,
	input  wire logic                       global_irq_enable_i,
	input  wire logic                       vector_access_i,
	output logic [dvt_pkg::NCHAN-1:0]       channel_done_flag_o,
	output logic [dvt_pkg::VEC_W-1:0]       dma_vector_reg_o,
	output logic                            irq_req_o,
	// serial unit
	input  wire logic                       serial_b_rx_set_i,
	input  wire logic                       serial_b_tx_set_i,
	input  wire logic                       serial_b_rx_irq_enable_i,
	input  wire logic                       serial_b_tx_irq_enable_i,
	input  wire logic                       serial_rx_ack_i,
	input  wire logic                       serial_tx_ack_i,
	output logic                            serial_b_rx_flag_o,
	output logic                            serial_b_tx_flag_o,
	output logic                            serial_rx_trig_o,
	output logic                            serial_tx_trig_o,
	// sar converter
	input  wire logic [SAR_SLOTS-1:0]       sar_result_set_i,
	input  wire logic [SAR_SLOTS-1:0]       sar_mem_access_i,
	input  wire logic [1:0]                 conversion_sequence_mode_i,
	input  wire logic [$clog2(SAR_SLOTS)-1:0] sar_conv_slot_i,
	input  wire logic [$clog2(SAR_SLOTS)-1:0] sar_last_slot_i,
	output logic [SAR_SLOTS-1:0]            sar_result_flag_o,
	output logic                            sar_trig_o,
	// dac
	input  wire logic                       dac_set_i,
	input  wire logic                       dac_data_access_i,
	output logic                            dac_irq_flag_o,
	output logic                            dac_trig_o,
	// sigma-delta
	input  wire logic [SD_CHANS-1:0]        sigma_delta_set_i,
	input  wire logic [SD_CHANS-1:0]        sigma_delta_access_i,
	input  wire logic [SD_CHANS-1:0]        sigma_delta_group_bit_i,
	input  wire logic                       sigma_delta_grouped_i,
	output logic [SD_CHANS-1:0]             sigma_delta_flag_o,
	output logic                            sigma_delta_trig_o
);

	localparam int SW = $clog2(SAR_SLOTS);
	localparam int DW = (SD_CHANS > 1) ? $clog2(SD_CHANS) : 1;

	// one-hot of the highest-priority enabled pending channel
	function automatic logic [dvt_pkg::NCHAN-1:0] pick_top(
		input logic [dvt_pkg::NCHAN-1:0] req
	);
		logic [dvt_pkg::NCHAN-1:0] sel;
		sel = '0;
		for (int i = dvt_pkg::NCHAN - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				sel = '0;
				sel[i] = 1'b1;
			end
		end
		return sel;
	endfunction

	// vector code of a one-hot channel; even steps index a jump table
	function automatic logic [3:0] chan_vec(
		input logic [dvt_pkg::NCHAN-1:0] sel
	);
		logic [3:0] code;
		code = dvt_pkg::VEC_NONE;
		unique case (sel)
			3'h1:    code = dvt_pkg::VEC_CHAN0;
			3'h2:    code = dvt_pkg::VEC_CHAN1;
			3'h4:    code = dvt_pkg::VEC_CHAN2;
			default: code = dvt_pkg::VEC_NONE;
		endcase
		return code;
	endfunction

	// channel that a vector code reports; reserved codes report none
	function automatic logic [dvt_pkg::NCHAN-1:0] vec_chan(
		input logic [3:0] code
	);
		logic [dvt_pkg::NCHAN-1:0] sel;
		sel = '0;
		unique case (code)
			dvt_pkg::VEC_CHAN0: sel = 3'h1;
			dvt_pkg::VEC_CHAN1: sel = 3'h2;
			dvt_pkg::VEC_CHAN2: sel = 3'h4;
			default:            sel = '0;
		endcase
		return sel;
	endfunction

	logic [dvt_pkg::NCHAN-1:0] done;
	logic [dvt_pkg::NCHAN-1:0] next_done;
	logic [dvt_pkg::NCHAN-1:0] enabled;
	logic [dvt_pkg::NCHAN-1:0] shown;
	logic [3:0]                vec;
	logic [3:0]                next_vec;
	logic                      irq;
	logic                      next_irq;

	assign enabled = next_done & channel_irq_enable_i;
	// clear what the vector shows, not a pick from this cycle's enables,
	// so an enable change beside the access cannot redirect the clear
	assign shown   = vec_chan(vec);

	always_comb
	begin
		// set wins over a software or vector clear in the same cycle
		next_done = (done & ~sw_flag_clr_i
			& ~(vector_access_i ? shown : '0)) | size_zero_i;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			done <= '0;
		else
			done <= next_done;
	end

	always_comb
	begin
		// vector follows the next flags so it is current with them
		next_vec = chan_vec(pick_top(enabled));
		// re-raised as soon as another enabled flag remains
		next_irq = global_irq_enable_i & |enabled;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			vec <= dvt_pkg::VEC_NONE;
			irq <= 1'b0;
		end
		else
		begin
			vec <= next_vec;
			irq <= next_irq;
		end
	end

	assign channel_done_flag_o = done;
	assign dma_vector_reg_o    = {{(dvt_pkg::VEC_W-4){1'b0}}, vec};
	assign irq_req_o           = irq;

	// peripheral flags: set wins over clear, so an event landing on the
	// acknowledge cycle is kept for the next transfer
	logic rx_f;
	logic tx_f;
	logic next_rx_f;
	logic next_tx_f;

	always_comb
	begin
		next_rx_f = serial_b_rx_set_i | (rx_f & ~serial_rx_ack_i);
		next_tx_f = serial_b_tx_set_i | (tx_f & ~serial_tx_ack_i);
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_f <= 1'b0;
			tx_f <= 1'b0;
		end
		else
		begin
			rx_f <= next_rx_f;
			tx_f <= next_tx_f;
		end
	end

	logic [SAR_SLOTS-1:0] sar_f;
	logic [SAR_SLOTS-1:0] next_sar_f;

	always_comb
	begin
		next_sar_f = sar_result_set_i
			| (sar_f & ~sar_mem_access_i);
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sar_f <= '0;
		else
			sar_f <= next_sar_f;
	end

	logic dac_f;
	logic next_dac_f;

	always_comb
	begin
		next_dac_f = dac_set_i | (dac_f & ~dac_data_access_i);
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			dac_f <= 1'b0;
		else
			dac_f <= next_dac_f;
	end

	logic [SD_CHANS-1:0] sd_f;
	logic [SD_CHANS-1:0] next_sd_f;

	always_comb
	begin
		next_sd_f = sigma_delta_set_i
			| (sd_f & ~sigma_delta_access_i);
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sd_f <= '0;
		else
			sd_f <= next_sd_f;
	end

	assign serial_b_rx_flag_o = rx_f;
	assign serial_b_tx_flag_o = tx_f;
	assign sar_result_flag_o  = sar_f;
	assign dac_irq_flag_o     = dac_f;
	assign sigma_delta_flag_o = sd_f;

	// sar trigger slot depends on sequence mode
	logic [SW-1:0] sar_sel;
	always_comb
	begin
		sar_sel = sar_conv_slot_i;
		unique case (conversion_sequence_mode_i)
			dvt_pkg::SEQ_SINGLE, dvt_pkg::SEQ_REPEAT:
				sar_sel = sar_conv_slot_i;
			dvt_pkg::SEQ_SEQUENCE, dvt_pkg::SEQ_REPEAT_SEQ:
				sar_sel = sar_last_slot_i;
		endcase
	end

	// sigma-delta master: lowest channel with group bit clear
	function automatic logic [DW-1:0] sd_master(
		input logic [SD_CHANS-1:0] grp
	);
		logic [DW-1:0] m;
		m = '0;
		for (int i = SD_CHANS - 1; i >= 0; i--)
		begin
			if (!grp[i])
				m = DW'(i);
		end
		return m;
	endfunction

	logic [DW-1:0] sd_sel;
	assign sd_sel = sigma_delta_grouped_i
		? sd_master(sigma_delta_group_bit_i)
		: '0;

	// triggers are pure level logic: no cpu state, so they run in any
	// power mode as long as mclk runs
	assign serial_rx_trig_o   = rx_f & ~serial_b_rx_irq_enable_i;
	assign serial_tx_trig_o   = tx_f & ~serial_b_tx_irq_enable_i;
	assign sar_trig_o         = sar_f[sar_sel];
	assign dac_trig_o         = dac_f;
	assign sigma_delta_trig_o = sd_f[sd_sel];

endmodule

//--- bench/dvt_chk.sv
// port assertions for the vector and trigger block
// assumes binding into dvt_core, one mclk_i domain
module dvt_chk (
	input wire logic [2:0]  size_zero_i,
	input wire logic        mclk_i,
	input wire logic        nrst_i,
	input wire logic [2:0]  channel_irq_enable_i,
	input wire logic        vector_access_i,
	input wire logic [2:0]  channel_done_flag_o,
	input wire logic [15:0] dma_vector_reg_o,
	input wire logic        irq_req_o,
	input wire logic        serial_b_rx_flag_o,
	input wire logic        serial_b_rx_irq_enable_i,
	input wire logic        serial_rx_trig_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	a_vec_even:
		assert property (!dma_vector_reg_o[0] && dma_vector_reg_o < 16'h8)
		else $error("vector odd or reserved");
	a_vec_top:
		assert property (channel_done_flag_o[0] && channel_irq_enable_i[0]
		&& $stable(channel_irq_enable_i) |-> dma_vector_reg_o == 16'h2)
		else $error("channel 0 not reported");
	a_vec_idle:
		assert property ($stable(channel_irq_enable_i) && !(|(
		channel_done_flag_o & channel_irq_enable_i)) |-> dma_vector_reg_o == 0)
		else $error("vector with nothing enabled");
	a_vec_last:
		assert property (dma_vector_reg_o == 16'h6 |-> channel_done_flag_o[2])
		else $error("vector 6 without channel 2");
	a_done_set:
		assert property (size_zero_i[1] |=> channel_done_flag_o[1])
		else $error("done flag not set");
	a_acc_clear:
		assert property (vector_access_i && dma_vector_reg_o == 16'h2
		&& !size_zero_i[0] |=> !channel_done_flag_o[0])
		else $error("access left reported flag");
	a_irq_cause:
		assert property (irq_req_o |-> |channel_done_flag_o)
		else $error("request without flag");
	a_rx_trig:
		assert property (serial_rx_trig_o == (serial_b_rx_flag_o
		&& !serial_b_rx_irq_enable_i)) else $error("rx trigger wrong");
endmodule

//--- bench/dvt_dma_model.sv
// dma side model: acks serial triggers at once or a cycle late
// assumes the core's mclk_i and nrst_i
module dvt_dma_model (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       slow_i,
	input  wire logic [1:0] trig_i,
	output logic      [1:0] ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen;
	// no second ack while the flag is still falling
	always_ff @(posedge mclk_i or negedge nrst_i)
		if (!nrst_i)
			{ack_o, seen} <= 3'h0;
		else
			{ack_o, seen} <= {(seen | !slow_i) && ack_o == 2'h0 ? trig_i
				: 2'h0, |trig_i};
endmodule

//--- bench/tb_dvt_core.sv
// self-checking bench for dvt_core beside a dma side model
// assumes package, core, checker and model compiled first
module tb_dvt_core;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, nrst_i = 0, global_irq_enable_i = 0, slow = 0;
	logic serial_b_rx_irq_enable_i, serial_b_tx_irq_enable_i, dac_set_i;
	logic sigma_delta_grouped_i, serial_rx_ack_i, serial_tx_ack_i;
	logic serial_b_rx_set_i, serial_b_tx_set_i, dac_data_access_i, irq_req_o;
	logic vector_access_i, serial_b_rx_flag_o, serial_b_tx_flag_o, dac_trig_o;
	logic serial_rx_trig_o, serial_tx_trig_o, sar_trig_o, dac_irq_flag_o;
	logic sigma_delta_trig_o;
	logic [1:0] conversion_sequence_mode_i;
	logic [2:0] size_zero_i, sw_flag_clr_i, channel_irq_enable_i;
	logic [2:0] channel_done_flag_o, sigma_delta_flag_o, sigma_delta_set_i;
	logic [2:0] sigma_delta_access_i, sigma_delta_group_bit_i;
	logic [3:0] sar_conv_slot_i, sar_last_slot_i;
	logic [15:0] dma_vector_reg_o, sar_result_flag_o;
	logic [15:0] sar_result_set_i, sar_mem_access_i;
	logic [18:0] p = '0;
	int seed = 90, err_count, cmp_count, cyc;
	// every pulse input but the dma model's acks from one word, so one task drives them all
	assign {dac_data_access_i, dac_set_i, sigma_delta_access_i,
		sigma_delta_set_i, serial_b_tx_set_i, serial_b_rx_set_i,
		sw_flag_clr_i, vector_access_i, size_zero_i} = p[16:0];
	assign sar_result_set_i = {12'h0, p[17], 3'h0};
	assign sar_mem_access_i = {12'h0, p[18], 3'h0};
	dvt_core u_dut (.*);
	dvt_dma_model u_dma (.mclk_i, .nrst_i, .slow_i(slow),
		.trig_i({serial_tx_trig_o, serial_rx_trig_o}),
		.ack_o({serial_tx_ack_i, serial_rx_ack_i}));
	initial forever #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc > 3000)
			finish_test;
	end
	function automatic logic [15:0] vx(input logic [2:0] m);
		return m[0] ? 16'h2 : m[1] ? 16'h4 : m[2] ? 16'h6 : 16'h0;
	endfunction
	task chk(input logic [15:0] got, exp);
		cmp_count++;
		err_count += int'(got !== exp);
		if (got !== exp)
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task pl(input logic [18:0] v);
		@(posedge mclk_i) p <= v;
		@(posedge mclk_i) p <= 19'h0;
		@(negedge mclk_i);
	endtask
	task finish_test;
		err_count += int'(cyc > 3000);
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		{serial_b_rx_irq_enable_i, serial_b_tx_irq_enable_i} = 2'h3;
		{sigma_delta_grouped_i, sigma_delta_group_bit_i} = 4'h9;
		channel_irq_enable_i = 3'h7;
		{conversion_sequence_mode_i, sar_conv_slot_i, sar_last_slot_i} = 10'h39;
		repeat (10) @(posedge mclk_i);
		nrst_i <= 1'b1;
		global_irq_enable_i <= 1'b1;
		@(negedge mclk_i) chk({channel_done_flag_o, irq_req_o}, 4'h0);
		pl(19'h5);
		chk(dma_vector_reg_o, vx(3'h5));
		pl(19'h8);
		chk({irq_req_o, channel_done_flag_o}, 4'hc);
		chk(dma_vector_reg_o, vx(3'h4));
		pl(19'h8);
		chk(irq_req_o, 16'h0);
		chk(dma_vector_reg_o, 16'h0);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge mclk_i) channel_irq_enable_i <= 3'(i);
			global_irq_enable_i <= 1'($random(seed));
			pl(19'h7);
			chk(dma_vector_reg_o, vx(3'(i)));
			chk(irq_req_o, 1'(i != 0) & global_irq_enable_i);
			pl(19'h70);
		end
		slow <= 1'b1;
		pl(19'h180);
		chk({serial_rx_trig_o, serial_tx_trig_o}, 2'h0);
		@(posedge mclk_i) serial_b_rx_irq_enable_i <= 1'b0;
		serial_b_tx_irq_enable_i <= 1'b0;
		@(negedge mclk_i) chk({serial_rx_trig_o, serial_tx_trig_o}, 2'h3);
		repeat (4) @(negedge mclk_i);
		chk({serial_b_rx_flag_o, serial_b_tx_flag_o}, 2'h0);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge mclk_i) conversion_sequence_mode_i <= 2'(m);
			pl(19'h20000);
			chk(sar_trig_o, 1'(!m[0]));
			pl(19'h40000);
			chk(sar_result_flag_o, 16'h0);
		end
		pl(19'h8400);
		chk({sigma_delta_trig_o, dac_trig_o}, 2'h3);
		@(posedge mclk_i) sigma_delta_grouped_i <= 1'b0;
		@(negedge mclk_i) chk(sigma_delta_trig_o, 1'b0);
		pl(19'h12000);
		chk({sigma_delta_flag_o, dac_irq_flag_o}, 4'h0);
		repeat (500)
		begin
			@(posedge mclk_i) p <= 19'($random(seed));
			{channel_irq_enable_i, slow} <= 4'($random(seed));
		end
		finish_test;
	end
endmodule
bind dvt_core dvt_chk u_chk (.*);
